// >>> hw/pixel_mask_raster_op_unit_defines.vh
// constants for the pixel mask and raster operation unit
`ifndef PIXEL_MASK_RASTER_OP_UNIT_DEFINES_VH
`define PIXEL_MASK_RASTER_OP_UNIT_DEFINES_VH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_PLANE_MASK 8'h04
`define OFS_STATUS 8'h08

// control register fields
`define CTL_OP_LSB 0
`define CTL_OP_MSB 4
`define CTL_TRANSP_BIT 5
`define CTL_SIZE_LSB 6
`define CTL_SIZE_MSB 8
`define CTL_WIDTH 9

// reset values
`define CONTROL_RESET 9'h000
`define PLANE_MASK_RESET 16'h0000

// pixel size codes
`define SIZE_1 3'h0
`define SIZE_2 3'h1
`define SIZE_4 3'h2
`define SIZE_8 3'h3
`define SIZE_16 3'h4

// low index masks per pixel size
`define LOWMASK_1 4'h0
`define LOWMASK_2 4'h1
`define LOWMASK_4 4'h3
`define LOWMASK_8 4'h7
`define LOWMASK_16 4'hf

// right-aligned pixel field masks per size code
`define FIELDMASK_1 16'h0001
`define FIELDMASK_2 16'h0003
`define FIELDMASK_4 16'h000f
`define FIELDMASK_8 16'h00ff
`define FIELDMASK_16 16'hffff

// pixel_op_select codes
`define OP_COPY 5'h00
`define OP_AND 5'h01
`define OP_AND_NOTD 5'h02
`define OP_ZEROS 5'h03
`define OP_OR_NOTD 5'h04
`define OP_XNOR 5'h05
`define OP_NOTD 5'h06
`define OP_NOR 5'h07
`define OP_OR 5'h08
`define OP_KEEPD 5'h09
`define OP_XOR 5'h0a
`define OP_NOTS_AND 5'h0b
`define OP_ONES 5'h0c
`define OP_NOTS_OR 5'h0d
`define OP_NAND 5'h0e
`define OP_NOTS 5'h0f
`define OP_ADD 5'h10
`define OP_ADD_SAT 5'h11
`define OP_SUB 5'h12
`define OP_SUB_SAT 5'h13
`define OP_MAX 5'h14
`define OP_MIN 5'h15

`endif

// >>> hw/pixel_mask_raster_op_unit.v
// pixel datapath: plane masking, raster operations, transparency and write mask
// Summary of operation
// - masked read: word AND inverted plane mask
// - register load: pixel right aligned, zero filled
// - transparent when whole masked pixel is zero
// - write mask: opaque pixels AND inverted mask
// - write takes result where mask one
// - sixteen boolean plus six arithmetic operations
// - boolean bitwise for sizes 1 to 16
// - arithmetic only for sizes 4, 8, 16
// - operation chosen by five bit select field
// - codes 0 to 7: first boolean group
// - codes 8 to 15: second boolean group
// - arithmetic codes 16 to 21, rest reserved
// - add/subtract wrap, no carry across pixels
// - saturating add overflows to all ones
// - saturating subtract underflows to all zeros
// - max writes larger, min writes smaller
// - read, mask, combine, mask, detect, write
// - result masked again after combining
// - flag destination read and read-modify-write need
// - transparency only while enable bit set
// - register sourced pixels bypass plane mask
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pixel_mask_raster_op_unit_defines.vh"

module pixel_mask_raster_op_unit (
	input wire ref_clk, // 25 MHz clock
	input wire rst_b, // asynchronous reset, active low
	input wire [7:0] regAddr, // register byte address
	input wire [31:0] regWrData, // register write data
	input wire regWr, // register write strobe
	input wire regRd, // register read strobe
	output wire [31:0] regRdData, // read data, cycle after strobe
	input wire opStart, // one-cycle pixel operation request
	input wire [15:0] srcWord, // source word from memory or register
	input wire srcFromReg, // source came from a processor register
	input wire [15:0] dstWord, // destination word read from memory
	input wire [3:0] pixelOffset, // bit offset of pixel for register load
	input wire unaligned, // access is not word aligned
	output wire outValid, // one-cycle pulse, results valid
	output wire [15:0] writeData, // merged word to write to memory
	output wire [15:0] writeMask, // bits that the write may change
	output wire [31:0] regPixel, // masked pixel for a general register
	output wire needDstRead, // destination read needed
	output wire needRmw // read-modify-write needed
);

	reg [`CTL_WIDTH-1:0] control_reg;
	reg [15:0] planeMask_reg;
	reg [31:0] rdData_reg;
	reg outValid_reg;
	reg [15:0] writeData_reg;
	reg [15:0] writeMask_reg;
	reg [31:0] regPixel_reg;
	reg needDstRead_reg;
	reg needRmw_reg;
	reg [15:0] lastOpaque_reg;
	reg lastUnsupported_reg;

	wire [4:0] opSel = control_reg[`CTL_OP_MSB:`CTL_OP_LSB];
	wire transpEn = control_reg[`CTL_TRANSP_BIT];
	wire [2:0] pixSize = control_reg[`CTL_SIZE_MSB:`CTL_SIZE_LSB];

	localparam SEL_NONE = 2'h0;
	localparam SEL_CONTROL = 2'h1;
	localparam SEL_MASK = 2'h2;
	localparam SEL_STATUS = 2'h3;

	// index bits that lie inside one pixel for a size code
	function [3:0] lowMask;
		input [2:0] sz;
		begin
			case (sz)
				`SIZE_1: lowMask = `LOWMASK_1;
				`SIZE_2: lowMask = `LOWMASK_2;
				`SIZE_4: lowMask = `LOWMASK_4;
				`SIZE_8: lowMask = `LOWMASK_8;
				default: lowMask = `LOWMASK_16;
			endcase
		end
	endfunction

	function pixStart;
		input [3:0] idx;
		input [2:0] sz;
		begin
			pixStart = ((idx & lowMask(sz)) == 4'h0);
		end
	endfunction

	function pixMsb;
		input [3:0] idx;
		input [2:0] sz;
		begin
			pixMsb = ((idx & lowMask(sz)) == lowMask(sz));
		end
	endfunction

	// bits of a right-aligned pixel; size codes above 16 bits act as 16
	function [15:0] fieldMask;
		input [2:0] sz;
		begin
			case (sz)
				`SIZE_1: fieldMask = `FIELDMASK_1;
				`SIZE_2: fieldMask = `FIELDMASK_2;
				`SIZE_4: fieldMask = `FIELDMASK_4;
				`SIZE_8: fieldMask = `FIELDMASK_8;
				default: fieldMask = `FIELDMASK_16;
			endcase
		end
	endfunction

	// arithmetic needs pixels of at least four bits
	function arithSizeOk;
		input [2:0] sz;
		begin
			case (sz)
				`SIZE_1: arithSizeOk = 1'b0;
				`SIZE_2: arithSizeOk = 1'b0;
				default: arithSizeOk = 1'b1;
			endcase
		end
	endfunction

	// register address decode, shared by the write and read ports
	function [1:0] regSelect;
		input [7:0] addr;
		begin
			if (addr == `OFS_CONTROL)
				regSelect = SEL_CONTROL;
			else if (addr == `OFS_PLANE_MASK)
				regSelect = SEL_MASK;
			else if (addr == `OFS_STATUS)
				regSelect = SEL_STATUS;
			else
				regSelect = SEL_NONE;
		end
	endfunction

	wire [1:0] regSel = regSelect(regAddr);

	// operands after plane masking; a register-sourced srcWord is used unmasked
	wire [15:0] srcMasked = srcWord & ~planeMask_reg;
	wire [15:0] srcOp = srcFromReg ? srcWord : srcMasked;
	wire [15:0] dstOp = dstWord & ~planeMask_reg;

	wire arithOp = opSel[4];
	wire sizeArithOk = arithSizeOk(pixSize);
	wire reservedOp = arithOp && (opSel > `OP_MIN);
	wire unsupported = reservedOp || (arithOp && !sizeArithOk);

	// boolean result, bit by bit for any pixel size
	reg [15:0] boolRes;
	always @*
	begin
		case (opSel[3:0])
			4'h0: boolRes = srcOp;
			4'h1: boolRes = srcOp & dstOp;
			4'h2: boolRes = srcOp & ~dstOp;
			4'h3: boolRes = 16'h0000;
			4'h4: boolRes = srcOp | ~dstOp;
			4'h5: boolRes = ~(srcOp ^ dstOp);
			4'h6: boolRes = ~dstOp;
			4'h7: boolRes = ~(srcOp | dstOp);
			4'h8: boolRes = srcOp | dstOp;
			4'h9: boolRes = dstOp;
			4'ha: boolRes = srcOp ^ dstOp;
			4'hb: boolRes = ~srcOp & dstOp;
			4'hc: boolRes = 16'hffff;
			4'hd: boolRes = ~srcOp | dstOp;
			4'he: boolRes = ~(srcOp & dstOp);
			default: boolRes = ~srcOp;
		endcase
	end

	// segmented adders: the carry chain restarts at every pixel boundary,
	// so one 16-bit ripple serves all pixel sizes without cross talk
	reg [15:0] sumBits;
	reg [15:0] diffBits;
	reg [15:0] sumCarryOut;
	reg [15:0] diffCarryOut;
	reg carryA;
	reg carryS;
	integer i;
	always @*
	begin
		sumBits = 16'h0000;
		diffBits = 16'h0000;
		sumCarryOut = 16'h0000;
		diffCarryOut = 16'h0000;
		carryA = 1'b0;
		carryS = 1'b1;
		for (i = 0; i < 16; i = i + 1)
		begin
			if (pixStart(i[3:0], pixSize))
			begin
				carryA = 1'b0;
				carryS = 1'b1;
			end
			sumBits[i] = dstOp[i] ^ srcOp[i] ^ carryA;
			carryA = (dstOp[i] & srcOp[i]) | (carryA & (dstOp[i] ^ srcOp[i]));
			sumCarryOut[i] = carryA;
			diffBits[i] = dstOp[i] ^ ~srcOp[i] ^ carryS;
			carryS = (dstOp[i] & ~srcOp[i]) | (carryS & (dstOp[i] ^ ~srcOp[i]));
			diffCarryOut[i] = carryS;
		end
	end

	// spread the flag taken at each pixel msb over the whole pixel
	reg [15:0] overflowFill;
	reg [15:0] noBorrowFill;
	reg curOvf;
	reg curNoBorrow;
	integer j;
	always @*
	begin
		overflowFill = 16'h0000;
		noBorrowFill = 16'h0000;
		curOvf = 1'b0;
		curNoBorrow = 1'b0;
		for (j = 15; j >= 0; j = j - 1)
		begin
			if (pixMsb(j[3:0], pixSize))
			begin
				curOvf = sumCarryOut[j];
				curNoBorrow = diffCarryOut[j];
			end
			overflowFill[j] = curOvf;
			noBorrowFill[j] = curNoBorrow;
		end
	end

	// arithmetic result, pixels as integers of 4, 8 or 16 bits
	reg [15:0] arithRes;
	always @*
	begin
		case (opSel)
			`OP_ADD: arithRes = sumBits;
			`OP_ADD_SAT: arithRes = sumBits | overflowFill;
			`OP_SUB: arithRes = diffBits;
			`OP_SUB_SAT: arithRes = diffBits & noBorrowFill;
			`OP_MAX: arithRes = (noBorrowFill & dstOp) | (~noBorrowFill & srcOp);
			`OP_MIN: arithRes = (noBorrowFill & srcOp) | (~noBorrowFill & dstOp);
			default: arithRes = dstOp;
		endcase
	end

	wire [15:0] rawRes = arithOp ? arithRes : boolRes;
	wire [15:0] resMasked = rawRes & ~planeMask_reg;

	// per-pixel nonzero detection on the masked result
	reg [15:0] nzAcc;
	reg accBit;
	integer k;
	always @*
	begin
		nzAcc = 16'h0000;
		accBit = 1'b0;
		for (k = 0; k < 16; k = k + 1)
		begin
			if (pixStart(k[3:0], pixSize))
				accBit = resMasked[k];
			else
				accBit = accBit | resMasked[k];
			nzAcc[k] = accBit;
		end
	end

	reg [15:0] opaqueMask;
	reg curNz;
	integer m;
	always @*
	begin
		opaqueMask = 16'h0000;
		curNz = 1'b0;
		for (m = 15; m >= 0; m = m - 1)
		begin
			if (pixMsb(m[3:0], pixSize))
				curNz = nzAcc[m];
			opaqueMask[m] = curNz;
		end
	end

	// without transparency every pixel counts as opaque
	wire [15:0] transpMask = transpEn ? opaqueMask : 16'hffff;
	wire [15:0] compMask = unsupported ? 16'h0000 :
		(transpMask & ~planeMask_reg);
	wire [15:0] mergedWord = (compMask & resMasked) | (~compMask & dstWord);

	// masked pixel shifted down for a register load
	wire [15:0] pixShifted = srcMasked >> pixelOffset;
	wire [15:0] pixField = pixShifted & fieldMask(pixSize);

	wire rmwCond = (((planeMask_reg != 16'h0000) || transpEn) &&
		(pixSize != `SIZE_16)) || unaligned;

	// outputs other than outValid held until the next request
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			outValid_reg <= 1'b0;
			writeData_reg <= 16'h0000;
			writeMask_reg <= 16'h0000;
			regPixel_reg <= 32'h00000000;
			needDstRead_reg <= 1'b0;
			needRmw_reg <= 1'b0;
			lastOpaque_reg <= 16'h0000;
			lastUnsupported_reg <= 1'b0;
		end
		else
		begin
			outValid_reg <= opStart;
			if (opStart)
			begin
				writeData_reg <= mergedWord;
				writeMask_reg <= compMask;
				regPixel_reg <= {16'h0000, pixField};
				needDstRead_reg <= (opSel != `OP_COPY);
				needRmw_reg <= rmwCond;
				lastOpaque_reg <= transpMask;
				lastUnsupported_reg <= unsupported;
			end
		end
	end

	// register writes; the plane mask is taken as written, replication is software's job
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			control_reg <= `CONTROL_RESET;
			planeMask_reg <= `PLANE_MASK_RESET;
		end
		else if (regWr)
		begin
			if (regSel == SEL_CONTROL)
				control_reg <= regWrData[`CTL_WIDTH-1:0];
			else if (regSel == SEL_MASK)
				planeMask_reg <= regWrData[15:0];
		end
	end

	// read data, valid only in the cycle after the strobe; unmapped reads zero
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdData_reg <= 32'h00000000;
		else if (regRd)
		begin
			if (regSel == SEL_CONTROL)
				rdData_reg <= {23'h000000, control_reg};
			else if (regSel == SEL_MASK)
				rdData_reg <= {16'h0000, planeMask_reg};
			else if (regSel == SEL_STATUS)
				rdData_reg <= {15'h0000, lastUnsupported_reg, lastOpaque_reg};
			else
				rdData_reg <= 32'h00000000;
		end
		else
			rdData_reg <= 32'h00000000;
	end

	assign regRdData = rdData_reg;
	assign outValid = outValid_reg;
	assign writeData = writeData_reg;
	assign writeMask = writeMask_reg;
	assign regPixel = regPixel_reg;
	assign needDstRead = needDstRead_reg;
	assign needRmw = needRmw_reg;

endmodule // pixel_mask_raster_op_unit

// >>> verification/pixel_mask_raster_op_unit_sva.sv
// port-level assertions for the pixel mask and raster operation unit
`timescale 1ns/1ps
module pixel_mask_raster_op_unit_sva (
	input wire ref_clk, // clock
	input wire rst_b, // async reset, active low
	input wire opStart, // op request
	input wire [15:0] dstWord, // raw destination
	input wire unaligned, // unaligned access
	input wire outValid, // result pulse
	input wire [15:0] writeData, // merged word
	input wire [15:0] writeMask, // write mask
	input wire [31:0] regPixel, // register pixel
	input wire needRmw // rmw flag
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	valid_pulse_a: assert property (opStart |=> outValid)
		else $error("result pulse missing");
	no_spurious_a: assert property (!opStart |=> !outValid)
		else $error("result pulse without request");
	data_hold_a: assert property (!opStart |=> $stable(writeData))
		else $error("write data moved while idle");
	mask_hold_a: assert property (!opStart |=> $stable(writeMask))
		else $error("write mask moved while idle");
	pixel_hold_a: assert property (!opStart |=> $stable(regPixel))
		else $error("register pixel moved while idle");
	merge_keep_a: assert property (outValid |-> ((writeData ^ $past(dstWord)) & ~writeMask) == 16'h0000)
		else $error("unmasked bit lost its destination value");
	pixel_upper_a: assert property (outValid |-> regPixel[31:16] == 16'h0000)
		else $error("register pixel upper bits not cleared");
	unaligned_rmw_a: assert property (opStart && unaligned |=> needRmw)
		else $error("unaligned access without rmw");
endmodule // pixel_mask_raster_op_unit_sva

// >>> verification/mem_word_model.sv
// local memory word that feeds the destination and takes masked writes
`timescale 1ns/1ps
module mem_word_model (
	input wire ref_clk, // clock
	input wire load, // preset the stored word
	input wire [15:0] loadWord, // word to preset
	input wire outValid, // write cycle
	input wire [15:0] writeData, // word from the datapath
	input wire [15:0] writeMask, // bits that may change
	output reg [15:0] dstWord // stored word
);
	initial dstWord = 16'h0000;
	// protected and transparent bits keep their old value
	always @(posedge ref_clk)
	begin
		if (load)
			dstWord <= loadWord;
		else if (outValid)
			dstWord <= (dstWord & ~writeMask) | (writeData & writeMask);
	end
endmodule // mem_word_model

// >>> verification/tb_top.sv
// self-checking bench for the pixel mask and raster operation unit
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [4:0] op;
		logic [2:0] sz;
		logic t;
		logic fr;
		logic un;
		logic [15:0] pm;
		logic [15:0] s;
		logic [15:0] d;
		logic [15:0] wd;
		logic [15:0] wm;
	} row_t;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic opStart = 1'b0;
	logic [15:0] srcWord = 16'h0000;
	logic srcFromReg = 1'b0;
	logic [3:0] pixelOffset = 4'h0;
	logic unaligned = 1'b0;
	logic load = 1'b0;
	logic [15:0] loadWord = 16'h0000;
	wire [31:0] regRdData, regPixel;
	wire [15:0] dstWord, writeData, writeMask;
	wire outValid, needDstRead, needRmw;
	int fail_count = 0;
	int check_count = 0;
	// op, size code, transp, reg source, unaligned, mask, src, dst, data, mask out
	row_t rows [11] = '{
		'{5'h10, 3'h2, 0, 0, 0, 16'h0000, 16'h1f32, 16'h2181, 16'h30b3, 16'hffff},
		'{5'h11, 3'h2, 0, 0, 0, 16'h0000, 16'h1f32, 16'h2181, 16'h3fb3, 16'hffff},
		'{5'h12, 3'h2, 0, 0, 0, 16'h0000, 16'h1f32, 16'h2181, 16'h125f, 16'hffff},
		'{5'h13, 3'h2, 0, 0, 0, 16'h0000, 16'h1f32, 16'h2181, 16'h1050, 16'hffff},
		'{5'h14, 3'h3, 0, 0, 0, 16'h0000, 16'h7f80, 16'h8070, 16'h8080, 16'hffff},
		'{5'h15, 3'h3, 0, 0, 0, 16'h0000, 16'h7f80, 16'h8070, 16'h7f70, 16'hffff},
		'{5'h00, 3'h3, 1, 0, 0, 16'hf8f8, 16'hf8f5, 16'haaaa, 16'haaad, 16'h0007},
		'{5'h12, 3'h2, 0, 1, 0, 16'h1111, 16'h0001, 16'h0000, 16'h000e, 16'heeee},
		'{5'h16, 3'h2, 0, 0, 1, 16'h0000, 16'h1234, 16'h5678, 16'h5678, 16'h0000},
		'{5'h10, 3'h1, 0, 0, 0, 16'h0000, 16'h1111, 16'h2222, 16'h2222, 16'h0000},
		'{5'h01, 3'h0, 1, 0, 0, 16'h0000, 16'hff00, 16'hf0f0, 16'hf0f0, 16'hf000}};
	logic [15:0] boolExp [16] = '{16'hff00, 16'hf000, 16'h0f00, 16'h0000, 16'hff0f,
		16'hf00f, 16'h0f0f, 16'h000f, 16'hfff0, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'hffff,
		16'hf0ff, 16'h0fff, 16'h00ff};
	pixel_mask_raster_op_unit dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.opStart(opStart), .srcWord(srcWord), .srcFromReg(srcFromReg), .dstWord(dstWord),
		.pixelOffset(pixelOffset), .unaligned(unaligned), .outValid(outValid),
		.writeData(writeData), .writeMask(writeMask), .regPixel(regPixel),
		.needDstRead(needDstRead), .needRmw(needRmw));
	mem_word_model mem (.ref_clk(ref_clk), .load(load), .loadWord(loadWord),
		.outValid(outValid), .writeData(writeData), .writeMask(writeMask), .dstWord(dstWord));
	always #20 ref_clk = ~ref_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		chk(regRdData, e);
	endtask
	task op(input logic [15:0] s, d, input logic fr, un, input logic [3:0] po);
		@(posedge ref_clk);
		load <= 1'b1;
		loadWord <= d;
		@(posedge ref_clk);
		load <= 1'b0;
		opStart <= 1'b1;
		srcWord <= s;
		srcFromReg <= fr;
		unaligned <= un;
		pixelOffset <= po;
		@(posedge ref_clk);
		opStart <= 1'b0;
		#1;
		chk(outValid, 1);
	endtask
	task run(input row_t r);
		wr(8'h00, {23'h0, r.sz, r.t, r.op});
		wr(8'h04, {16'h0, r.pm});
		op(r.s, r.d, r.fr, r.un, 4'h0);
		chk(writeData, r.wd);
		chk(writeMask, r.wm);
		chk(needDstRead, r.op != 5'h00);
		chk(needRmw, ((r.pm != 16'h0 || r.t) && r.sz != 3'h4) || r.un);
		@(posedge ref_clk);
		#1;
		chk(dstWord, r.wd);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run;
	end
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 16; i++)
			run('{i[4:0], 3'h4, 0, 0, 0, 16'h0, 16'hff00, 16'hf0f0, boolExp[i], 16'hffff});
		for (int i = 0; i < 11; i++)
			run(rows[i]);
		$display("table done");
		run(rows[6]);
		rd(8'h08, 32'h000000ff);
		run(rows[8]);
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h0001ffff);
		$display("status done");
		wr(8'h00, 32'h000000c0);
		wr(8'h04, 32'h0000f0f0);
		op(16'habcd, 16'h0000, 0, 0, 4'h8);
		chk(regPixel, 32'h0000000b);
		chk(writeData, 16'h0b0d);
		$display("register pixel done");
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0);
		@(posedge ref_clk);
		opStart <= 1'b1;
		srcWord <= 16'h1234;
		@(posedge ref_clk);
		srcWord <= 16'h5678;
		#1;
		chk(writeData, 16'h1234);
		@(posedge ref_clk);
		opStart <= 1'b0;
		#1;
		chk({outValid, writeData}, {1'b1, 16'h5678});
		$display("back to back done");
		wr(8'h00, 32'hffffffff);
		rd(8'h00, 32'h000001ff);
		wr(8'h04, 32'hffffffff);
		rd(8'h04, 32'h0000ffff);
		wr(8'h0c, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h00, 32'h000001ff);
		$display("registers done");
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({outValid, needDstRead, needRmw, writeData}, 32'h0);
		chk({writeMask, regPixel[15:0]}, 32'h0);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		$display("reset done");
		complete_run;
	end
endmodule // tb_top
bind pixel_mask_raster_op_unit pixel_mask_raster_op_unit_sva sva_chk (.ref_clk(ref_clk),
	.rst_b(rst_b), .opStart(opStart), .dstWord(dstWord), .unaligned(unaligned),
	.outValid(outValid), .writeData(writeData), .writeMask(writeMask),
	.regPixel(regPixel), .needRmw(needRmw));
